// ### verilog/starter_status_regs.sv
`timescale 1ns/1ps
module starter_status_regs #(
  parameter int PCT_IN_W = 16,
  parameter int HIST_DEPTH = 3
) (
  // clock, reset and enable
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  input  wire logic                               clk_en,
  // starter state from the control logic
  input  wire starter_status_pkg::control_flags_t control_flags,
  input  wire starter_status_pkg::fault_flags_t   fault_flags,
  input  wire starter_status_pkg::warning_flags_t warning_flags,
  // event code stream
  input  wire logic                               event_push,
  input  wire logic [15:0]                        event_code,
  // measurements, already scaled to percent, may exceed 255
  input  wire logic [PCT_IN_W-1:0]                current_pct_raw,
  input  wire logic [PCT_IN_W-1:0]                thermal_pct_raw,
  // register read port
  input  wire starter_status_pkg::read_req_t      read_req,
  output logic                                    rd_valid,
  output logic                                    rd_err,
  output logic      [15:0]                        rd_data
);

  // ============================================================
  // helpers
  // ============================================================
  // clamp a wide percent to the 8-bit register range
  function automatic logic [7:0] sat_percent(input logic [PCT_IN_W-1:0] v);
    logic [PCT_IN_W-1:0] lim;
    lim = PCT_IN_W'(starter_status_pkg::PERCENT_MAX);
    if (v > lim)
      sat_percent = starter_status_pkg::PERCENT_MAX;
    else
      sat_percent = v[7:0];
  endfunction

  // ============================================================
  // captured state
  // ============================================================
  logic [7:0]  state_r;
  logic [7:0]  state_nxt;
  logic [15:0] fault_r;
  logic [15:0] fault_nxt;
  logic [15:0] warning_r;
  logic [15:0] warning_nxt;
  logic [7:0]  current_pct_r;
  logic [7:0]  current_pct_nxt;
  logic [7:0]  thermal_pct_r;
  logic [7:0]  thermal_pct_nxt;

  logic [HIST_DEPTH-1:0][15:0] hist_codes;

  // read port state
  logic        rd_valid_r;
  logic        rd_err_r;
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;

  // ============================================================
  // bitmap assembly
  // ============================================================
  wire any_fault   = |fault_nxt;
  wire any_warning = |warning_nxt;

  always_comb
  begin
    fault_nxt = starter_status_pkg::BITMAP_RESET;
    fault_nxt[starter_status_pkg::CONDITION_COUNT-1:0] = fault_flags.conditions;
    fault_nxt[starter_status_pkg::FAULT_HALT_BIT]  = fault_flags.emergency_halt;
    fault_nxt[starter_status_pkg::FAULT_OTHER_BIT] = fault_flags.other;
  end

  always_comb
  begin
    warning_nxt = starter_status_pkg::BITMAP_RESET;
    warning_nxt[starter_status_pkg::CONDITION_COUNT-1:0] = warning_flags.conditions;
    warning_nxt[starter_status_pkg::WARN_IMPENDING_BIT] = warning_flags.impending_trip;
    warning_nxt[starter_status_pkg::WARN_OTHER_BIT]     = warning_flags.other;
  end

  // ============================================================
  // state word
  // ============================================================
  // fault and warning bits follow the bitmaps so the two views never disagree
  always_comb
  begin
    state_nxt = starter_status_pkg::STATE_RESET;
    state_nxt[starter_status_pkg::STATE_RUN_A_BIT]   = control_flags.run_state_a;
    state_nxt[starter_status_pkg::STATE_RUN_B_BIT]   = control_flags.run_state_b;
    state_nxt[starter_status_pkg::STATE_PERMIT_BIT]  = control_flags.start_permitted;
    state_nxt[starter_status_pkg::STATE_SECOND_RAMP_ACTIVE_BIT]   = control_flags.second_ramp_active;
    state_nxt[starter_status_pkg::STATE_LOCAL_BIT]   = control_flags.local_command_source;
    state_nxt[starter_status_pkg::STATE_FAULT_BIT]   = any_fault;
    state_nxt[starter_status_pkg::STATE_WARNING_BIT] = any_warning;
    state_nxt[starter_status_pkg::STATE_BYPASS_BIT]  = control_flags.bypass_engaged;
  end

  // ============================================================
  // percent measurements
  // ============================================================
  // scaling to rated motor amps happens upstream; only the clamp lives here
  assign current_pct_nxt = sat_percent(current_pct_raw);
  assign thermal_pct_nxt = sat_percent(thermal_pct_raw);

  // ============================================================
  // status capture
  // ============================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r       <= starter_status_pkg::STATE_RESET;
      fault_r       <= starter_status_pkg::BITMAP_RESET;
      warning_r     <= starter_status_pkg::BITMAP_RESET;
      current_pct_r <= starter_status_pkg::PERCENT_RESET;
      thermal_pct_r <= starter_status_pkg::PERCENT_RESET;
    end
    else if (clk_en)
    begin
      state_r       <= state_nxt;
      fault_r       <= fault_nxt;
      warning_r     <= warning_nxt;
      current_pct_r <= current_pct_nxt;
      thermal_pct_r <= thermal_pct_nxt;
    end
  end

  // ============================================================
  // event code history
  // ============================================================
  // a code pushed while clk_en is low is dropped, so the producer must hold it
  event_history #(
    .CODE_W (16),
    .DEPTH  (HIST_DEPTH)
  ) u_history (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .push    (event_push),
    .code    (event_code),
    .entries (hist_codes)
  );

  // ============================================================
  // register map
  // ============================================================
  logic [15:0] reg_words [starter_status_pkg::REG_COUNT];

  assign reg_words[0] = {8'h00, state_r};
  assign reg_words[1] = hist_codes[0];
  assign reg_words[2] = hist_codes[1];
  assign reg_words[3] = hist_codes[2];
  assign reg_words[4] = fault_r;
  assign reg_words[5] = warning_r;
  assign reg_words[6] = {8'h00, current_pct_r};
  assign reg_words[7] = {8'h00, thermal_pct_r};

  wire        addr_hit = (read_req.addr >= starter_status_pkg::REG_FIRST) &&
                         (read_req.addr <= starter_status_pkg::REG_LAST);
  wire [15:0] addr_off = read_req.addr - starter_status_pkg::REG_FIRST;
  wire [2:0]  word_idx = addr_off[2:0];

  // unmapped numbers answer zero with the error flag
  assign rd_data_nxt = addr_hit ? reg_words[word_idx] : starter_status_pkg::READ_DATA_RESET;

  // ============================================================
  // read answer
  // ============================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid_r <= 1'b0;
      rd_err_r   <= 1'b0;
      rd_data_r  <= starter_status_pkg::READ_DATA_RESET;
    end
    else if (clk_en)
    begin
      rd_valid_r <= read_req.en;
      rd_err_r   <= read_req.en && !addr_hit;
      if (read_req.en)
        rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_valid = rd_valid_r;
  assign rd_err   = rd_err_r;
  assign rd_data  = rd_data_r;

endmodule

// ### verilog/starter_status_pkg.sv
// ============================================================
// register numbers, field positions and reset values
// ============================================================
package starter_status_pkg;

  // register numbers as seen by the network master
  localparam logic [15:0] REG_MOTOR_CONTROL_STATE   = 16'h012c;
  localparam logic [15:0] REG_LATEST_EVENT_CODE     = 16'h012d;
  localparam logic [15:0] REG_SECOND_EVENT_CODE     = 16'h012e;
  localparam logic [15:0] REG_THIRD_EVENT_CODE      = 16'h012f;
  localparam logic [15:0] REG_FAULT_BITMAP          = 16'h0130;
  localparam logic [15:0] REG_WARNING_BITMAP        = 16'h0131;
  localparam logic [15:0] REG_AVERAGE_CURRENT_PCT   = 16'h0132;
  localparam logic [15:0] REG_THERMAL_USAGE_PCT     = 16'h0133;
  localparam logic [15:0] REG_FIRST                 = 16'h012c;
  localparam logic [15:0] REG_LAST                  = 16'h0133;
  localparam int          REG_COUNT                 = 8;

  // motor control state word bit positions
  localparam int STATE_RUN_A_BIT       = 0;
  localparam int STATE_RUN_B_BIT       = 1;
  localparam int STATE_PERMIT_BIT      = 2;
  localparam int STATE_SECOND_RAMP_ACTIVE_BIT       = 3;
  localparam int STATE_LOCAL_BIT       = 4;
  localparam int STATE_FAULT_BIT       = 5;
  localparam int STATE_WARNING_BIT     = 6;
  localparam int STATE_BYPASS_BIT      = 7;

  // fault and warning bitmap positions
  localparam int CONDITION_COUNT       = 10;
  localparam int FAULT_HALT_BIT        = 11;
  localparam int FAULT_OTHER_BIT       = 15;
  localparam int WARN_IMPENDING_BIT    = 10;
  localparam int WARN_OTHER_BIT        = 15;

  // values after reset, and the percent clamp limit
  localparam logic [15:0] EVENT_CODE_RESET  = 16'h0000;
  localparam logic [7:0]  STATE_RESET       = 8'h00;
  localparam logic [15:0] BITMAP_RESET      = 16'h0000;
  localparam logic [7:0]  PERCENT_RESET     = 8'h00;
  localparam logic [7:0]  PERCENT_MAX       = 8'hff;
  localparam logic [15:0] READ_DATA_RESET   = 16'h0000;

  typedef struct packed {
    logic bypass_engaged;
    logic local_command_source;
    logic second_ramp_active;
    logic start_permitted;
    logic run_state_b;
    logic run_state_a;
  } control_flags_t;

  typedef struct packed {
    logic       other;
    logic       emergency_halt;
    logic [9:0] conditions;
  } fault_flags_t;

  typedef struct packed {
    logic       other;
    logic       impending_trip;
    logic [9:0] conditions;
  } warning_flags_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
  } read_req_t;

endpackage

// ### verilog/event_history.sv
`timescale 1ns/1ps
// ============================================================
// newest-first history of fault and warning codes
// ============================================================
module event_history #(
  parameter int CODE_W = 16,
  parameter int DEPTH  = 3
) (
  // clock, reset and enable
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  // new code
  input  wire logic                         push,
  input  wire logic [CODE_W-1:0]            code,
  // stored codes, entry 0 newest
  output logic      [DEPTH-1:0][CODE_W-1:0] entries
);

  logic [DEPTH-1:0][CODE_W-1:0] hist_r;

  assign entries = hist_r;

  // ============================================================
  // shift chain
  // ============================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hist_r[0] <= CODE_W'(starter_status_pkg::EVENT_CODE_RESET);
    else if (clk_en && push)
      hist_r[0] <= code;
  end

  genvar g;
  generate
    for (g = 1; g < DEPTH; g++)
    begin : g_shift
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          hist_r[g] <= CODE_W'(starter_status_pkg::EVENT_CODE_RESET);
        else if (clk_en && push)
          hist_r[g] <= hist_r[g-1];
      end
    end
  endgenerate

endmodule

// ### sim/starter_status_regs_asserts.sv
`timescale 1ns/1ps
// ==========================================
// read port and register content checks
// ==========================================
module starter_status_regs_asserts #(
  parameter int PCT_IN_W = 16
) (
  // clock, reset and enable
  input wire logic                               clk_sys,
  input wire logic                               rst_n,
  input wire logic                               clk_en,
  // status inputs
  input wire starter_status_pkg::control_flags_t control_flags,
  input wire starter_status_pkg::fault_flags_t   fault_flags,
  input wire starter_status_pkg::warning_flags_t warning_flags,
  input wire logic                               event_push,
  input wire logic [15:0]                        event_code,
  input wire logic [PCT_IN_W-1:0]                current_pct_raw,
  input wire logic [PCT_IN_W-1:0]                thermal_pct_raw,
  // read port
  input wire starter_status_pkg::read_req_t      read_req,
  input wire logic                               rd_valid,
  input wire logic                               rd_err,
  input wire logic [15:0]                        rd_data
);
  logic [15:0] state_now;
  logic [15:0] fmap;
  logic [15:0] wmap;
  logic [15:0] cur_sat;
  logic [15:0] thr_sat;
  logic        rd_go;
  logic        bad_addr;
  assign rd_go = read_req.en && clk_en;
  assign bad_addr = read_req.addr < 16'h012c || read_req.addr > 16'h0133;
  assign state_now = {8'h00, control_flags.bypass_engaged, |warning_flags, |fault_flags,
                      control_flags.local_command_source, control_flags[3:0]};
  assign fmap = {fault_flags.other, 3'h0, fault_flags.emergency_halt, 1'b0, fault_flags.conditions};
  assign wmap = {warning_flags.other, 4'h0, warning_flags.impending_trip, warning_flags.conditions};
  assign cur_sat = {8'h00, (current_pct_raw > 255) ? 8'hff : current_pct_raw[7:0]};
  assign thr_sat = {8'h00, (thermal_pct_raw > 255) ? 8'hff : thermal_pct_raw[7:0]};
  // a register read returns what was captured one edge before the read was taken
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  read_answer_a: assert property (rd_go |=> rd_valid) else $error("read not answered");
  answer_cause_a: assert property (rd_valid |-> $past(rd_go)) else $error("answer without read");
  unmapped_err_a: assert property (rd_go && bad_addr |=> rd_err && rd_data == 16'h0000)
    else $error("unmapped read not refused");
  state_word_a: assert property (rd_go && read_req.addr == 16'h012c |=> rd_data == $past(state_now, 2))
    else $error("state word wrong");
  fault_map_a: assert property (rd_go && read_req.addr == 16'h0130 |=> rd_data == $past(fmap, 2))
    else $error("fault bitmap wrong");
  warn_map_a: assert property (rd_go && read_req.addr == 16'h0131 |=> rd_data == $past(wmap, 2))
    else $error("warning bitmap wrong");
  current_sat_a: assert property (rd_go && read_req.addr == 16'h0132 |=> rd_data == $past(cur_sat, 2))
    else $error("current percent wrong");
  thermal_sat_a: assert property (rd_go && read_req.addr == 16'h0133 |=> rd_data == $past(thr_sat, 2))
    else $error("thermal percent wrong");
  newest_code_a: assert property (event_push && clk_en ##1 rd_go && read_req.addr == 16'h012d
    |=> rd_data == $past(event_code, 2)) else $error("newest code wrong");
  read_ok_c: cover property (rd_valid && !rd_err);
  read_bad_c: cover property (rd_valid && rd_err);
  push_c: cover property (event_push && clk_en);
endmodule
bind starter_status_regs starter_status_regs_asserts #(.PCT_IN_W(PCT_IN_W)) chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .clk_en(clk_en), .control_flags(control_flags), .fault_flags(fault_flags),
  .warning_flags(warning_flags), .event_push(event_push), .event_code(event_code),
  .current_pct_raw(current_pct_raw), .thermal_pct_raw(thermal_pct_raw), .read_req(read_req),
  .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data));

// ### sim/status_master.sv
`timescale 1ns/1ps
// ==========================================
// network master issuing register reads
// ==========================================
module status_master (
  // clock
  input wire logic                          clk_sys,
  // read request
  output starter_status_pkg::read_req_t     read_req
);
  initial read_req = '0;
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    read_req <= '{en: 1'b1, addr: a};
    @(posedge clk_sys);
    // a released address shows its inverse so stale values are never trusted
    read_req <= '{en: 1'b0, addr: ~a};
  endtask
endmodule

// ### sim/test_starter_status_regs.sv
`timescale 1ns/1ps
module test_starter_status_regs;
  logic clk_sys, rst_n, clk_en, event_push, rd_valid, rd_err;
  logic [15:0] event_code, cur, thr, rd_data, v;
  logic [2:0][15:0] hist;
  logic [16:0] exp_q[$];
  starter_status_pkg::control_flags_t cf;
  starter_status_pkg::fault_flags_t ff;
  starter_status_pkg::warning_flags_t wf;
  starter_status_pkg::read_req_t read_req;
  int err_total, num_checks;
  status_master m (.clk_sys(clk_sys), .read_req(read_req));
  starter_status_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .control_flags(cf),
    .fault_flags(ff), .warning_flags(wf), .event_push(event_push), .event_code(event_code),
    .current_pct_raw(cur), .thermal_pct_raw(thr), .read_req(read_req), .rd_valid(rd_valid),
    .rd_err(rd_err), .rd_data(rd_data));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] exp_reg(input logic [15:0] a);
    case (a)
      16'h012c: return {8'h00, cf.bypass_engaged, |wf, |ff, cf.local_command_source, cf[3:0]};
      16'h012d: return hist[0];
      16'h012e: return hist[1];
      16'h012f: return hist[2];
      16'h0130: return {ff.other, 3'h0, ff.emergency_halt, 1'b0, ff.conditions};
      16'h0131: return {wf.other, 4'h0, wf.impending_trip, wf.conditions};
      16'h0132: return {8'h00, (cur > 255) ? 8'hff : cur[7:0]};
      16'h0133: return {8'h00, (thr > 255) ? 8'hff : thr[7:0]};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic rd_chk(input logic [15:0] a);
    exp_q.push_back({a < 16'h012c || a > 16'h0133, exp_reg(a)});
    m.rd(a);
  endtask
  task automatic chk(input logic [16:0] e, input logic [16:0] got);
    num_checks++;
    if (got !== e)
    begin
      err_total++;
      $display("BAD %0t read got %h want %h", $time, got, e);
    end
  endtask
  // ==========================================
  // answer monitor, compares against the oldest note
  // ==========================================
  always @(negedge clk_sys)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(17'h1ffff, {rd_err, rd_data});
      else
        chk(exp_q.pop_front(), {rd_err, rd_data});
    end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_total++;
    print_verdict();
  end
  // ==========================================
  // tests
  // ==========================================
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    cf = '0;
    ff = '0;
    wf = '0;
    event_push = 1'b0;
    event_code = '0;
    cur = '0;
    thr = '0;
    hist = '0;
    v = 16'($urandom(92));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int a = 'h012b; a <= 'h0134; a++) rd_chk(a[15:0]);
    $display("test reset and unmapped done");
    repeat (20)
    begin
      @(posedge clk_sys);
      cf <= 6'($urandom);
      ff <= 12'($urandom);
      wf <= 12'($urandom);
      cur <= 16'($urandom_range(0, 300));
      thr <= 16'($urandom_range(0, 300));
      repeat (2) @(posedge clk_sys);
      for (int a = 'h012c; a <= 'h0133; a++) rd_chk(a[15:0]);
    end
    $display("test random status done");
    repeat (4)
    begin
      @(posedge clk_sys);
      v = 16'($urandom);
      event_push <= 1'b1;
      event_code <= v;
      hist = {hist[1:0], v};
    end
    fork
      rd_chk(16'h012d);
      begin
        @(posedge clk_sys);
        event_push <= 1'b0;
      end
    join
    for (int a = 'h012d; a <= 'h012f; a++) rd_chk(a[15:0]);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    event_push <= 1'b1;
    event_code <= ~hist[0];
    @(posedge clk_sys);
    clk_en <= 1'b1;
    event_push <= 1'b0;
    rd_chk(16'h012d);
    $display("test history done");
    repeat (4) @(posedge clk_sys);
    print_verdict();
  end
endmodule
